// ### src/week_timer_pkg.sv
// constants, offsets and reset values of the week timer core
package week_timer_pkg;
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SECONDS = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_ALARM = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_PRESCALER = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_RATE = 5'h10;
   localparam int RUN_BIT = 0;
   localparam int SECONDS_W = 28;
   localparam int PRESC_W = 15;
   localparam int RATE_W = 4;
   localparam logic [SECONDS_W-1:0] SECONDS_RESET = 28'h000_0000;
   localparam logic [SECONDS_W-1:0] ALARM_RESET = 28'h0ff_ffff;
   localparam logic [RATE_W-1:0] RATE_RESET = 4'h0;
   localparam logic [RATE_W-1:0] RATE_OFF = 4'h0;
   localparam logic [RATE_W-1:0] RATE_MAX = 4'hf;
   localparam logic [PRESC_W-1:0] PRESC_RESET = 15'h0000;
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_HZ = 32_768;
   localparam int ACC_W = 28;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : week_timer_pkg

// ### src/week_timer_counter_core.sv
// week timer core: prescaler, seconds counter, alarm compare, sub-second tap, axi4-lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module week_timer_counter_core
   import week_timer_pkg::*;
#(
   parameter int CLK_FREQ_HZ = CLK_HZ,
   parameter int TICK_FREQ_HZ = TICK_HZ
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic week_alarm_irq,
   output logic week_powerup_event,
   output logic subsecond_irq,
   output logic subsecond_time_base
);
   // write channel holding
   logic aw_held_ff;
   logic w_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   // timer state
   logic run_ff;
   logic [SECONDS_W-1:0] seconds_ff;
   logic [SECONDS_W-1:0] alarm_ff;
   logic [RATE_W-1:0] rate_ff;
   logic [PRESC_W-1:0] presc_ff;
   logic [ACC_W-1:0] acc_ff;
   logic tick_ff;
   logic sec_pend_ff;
   logic [SECONDS_W-1:0] sec_load_ff;
   logic tap_prev_ff;
   logic alarm_irq_ff;
   logic powerup_ff;
   logic subsec_ff;
   logic tap_ff;
   logic awready_ff;
   logic wready_ff;

   logic do_write;
   logic [31:0] cur_word;
   logic [31:0] new_word;
   logic [ACC_W-1:0] nxt_acc;
   logic [ACC_W:0] acc_sum;
   logic tap_now;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic nxt_aw_held;
   logic nxt_w_held;
   logic nxt_bvalid;

   localparam logic [ACC_W:0] ACC_STEP = (ACC_W+1)'(TICK_FREQ_HZ);
   localparam logic [ACC_W:0] ACC_WRAP = (ACC_W+1)'(CLK_FREQ_HZ);

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign week_alarm_irq = alarm_irq_ff;
   assign week_powerup_event = powerup_ff;
   assign subsecond_irq = subsec_ff;
   assign subsecond_time_base = tap_ff;

   assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

   // next holding state, so both ready outputs come straight from flops
   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_bvalid = bvalid_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
      end else if (do_write) begin
         nxt_aw_held = 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
      end else if (do_write) begin
         nxt_w_held = 1'b0;
      end
      if (do_write) begin
         nxt_bvalid = 1'b1;
      end else if (s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
      end else begin
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b0;
      end else begin
         wready_ff <= ~nxt_w_held & ~nxt_bvalid;
      end
   end

   // current word of the addressed register, for byte-lane merging
   always_comb begin
      cur_word = 32'h0000_0000;
      wr_hit = 1'b1;
      case (awaddr_ff)
         OFS_CONTROL: cur_word[RUN_BIT] = run_ff;
         OFS_SECONDS: cur_word[SECONDS_W-1:0] = sec_pend_ff ? sec_load_ff : seconds_ff;
         OFS_ALARM: cur_word[SECONDS_W-1:0] = alarm_ff;
         OFS_PRESCALER: cur_word[PRESC_W-1:0] = presc_ff;
         OFS_RATE: cur_word[RATE_W-1:0] = rate_ff;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         new_word[i*8 +: 8] = wstrb_ff[i] ? wdata_ff[i*8 +: 8] : cur_word[i*8 +: 8];
      end
   end

   // write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         awaddr_ff <= OFS_CONTROL;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         awaddr_ff <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (wr_hit && awaddr_ff != OFS_PRESCALER) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // read: data one cycle after the address is taken
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
         OFS_CONTROL: rd_word[RUN_BIT] = run_ff;
         OFS_SECONDS: rd_word[SECONDS_W-1:0] = seconds_ff;
         OFS_ALARM: rd_word[SECONDS_W-1:0] = alarm_ff;
         OFS_PRESCALER: rd_word[PRESC_W-1:0] = presc_ff;
         OFS_RATE: rd_word[RATE_W-1:0] = rate_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (rvalid_ff) begin
         arready_ff <= 1'b0;
         if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end else if (s_axi_arvalid && !arready_ff) begin
         arready_ff <= 1'b1;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_word;
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else begin
         arready_ff <= 1'b0;
      end
   end

   // fractional divider: one tick enable per prescaler count, TICK_FREQ_HZ of them per CLK_FREQ_HZ clock cycles
   always_comb begin
      acc_sum = {1'b0, acc_ff} + ACC_STEP;
      if (acc_sum >= ACC_WRAP) begin
         nxt_acc = ACC_W'(acc_sum - ACC_WRAP);
      end else begin
         nxt_acc = acc_sum[ACC_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         tick_ff <= (acc_sum >= ACC_WRAP);
      end
   end

   // control and configuration writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_ff <= 1'b0;
         alarm_ff <= ALARM_RESET;
         rate_ff <= RATE_RESET;
      end else if (do_write) begin
         case (awaddr_ff)
            OFS_CONTROL: run_ff <= new_word[RUN_BIT];
            OFS_ALARM: alarm_ff <= new_word[SECONDS_W-1:0];
            OFS_RATE: rate_ff <= new_word[RATE_W-1:0];
            default: run_ff <= run_ff;
         endcase
      end
   end

   // prescaler stops at zero while not running
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_ff <= PRESC_RESET;
      end else if (!run_ff) begin
         presc_ff <= PRESC_RESET;
      end else if (tick_ff) begin
         presc_ff <= presc_ff + 1'b1;
      end
   end

   // seconds write staged until the next tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_pend_ff <= 1'b0;
         sec_load_ff <= SECONDS_RESET;
      end else if (do_write && awaddr_ff == OFS_SECONDS) begin
         sec_pend_ff <= 1'b1;
         sec_load_ff <= new_word[SECONDS_W-1:0];
      end else if (tick_ff) begin
         sec_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seconds_ff <= SECONDS_RESET;
      end else if (tick_ff && sec_pend_ff) begin
         seconds_ff <= sec_load_ff;
      end else if (tick_ff && run_ff && presc_ff == PRESC_RESET) begin
         seconds_ff <= seconds_ff + 1'b1;
      end
   end

   // alarm compare, level while at or above threshold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_irq_ff <= 1'b0;
         powerup_ff <= 1'b0;
      end else begin
         alarm_irq_ff <= (seconds_ff >= alarm_ff);
         powerup_ff <= (seconds_ff >= alarm_ff);
      end
   end

   // selected tap: rate 0 none, rate n uses prescaler bit 14-n, rate 15 the tick itself
   always_comb begin
      tap_now = 1'b0;
      if (rate_ff == RATE_MAX) begin
         tap_now = tick_ff & run_ff;
      end else if (rate_ff != RATE_OFF) begin
         tap_now = presc_ff[4'(4'd14 - rate_ff)];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tap_prev_ff <= 1'b0;
         tap_ff <= 1'b0;
         subsec_ff <= 1'b0;
      end else begin
         tap_prev_ff <= tap_now;
         tap_ff <= tap_now;
         if (rate_ff == RATE_OFF) begin
            subsec_ff <= 1'b0;
         end else if (rate_ff == RATE_MAX) begin
            subsec_ff <= tap_now;
         end else begin
            subsec_ff <= tap_now & ~tap_prev_ff;
         end
      end
   end
endmodule : week_timer_counter_core

// ### test/week_timer_counter_core_chk.sv
// bus handshake and event assertions for the week timer core
`timescale 1ns/1ps
module week_timer_counter_core_chk
   import week_timer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic week_alarm_irq,
   input wire logic week_powerup_event,
   input wire logic subsecond_irq,
   input wire logic subsecond_time_base
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_WR_ANSWER:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:3] s_axi_bvalid) else $error("no write response");
   AST_RD_ANSWER:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
         else $error("read answer late");
   AST_B_DROP:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
   AST_R_DROP:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
   AST_AR_PULSE:
      assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
   AST_BUSY_REFUSE:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
         else $error("ready while response open");
   AST_RSVD_ZERO:
      assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:28] == 4'h0)
         else $error("reserved bits set");
   AST_ALARM_PAIR:
      assert property (week_alarm_irq == week_powerup_event) else $error("alarm and event differ");
   AST_SUB_PULSE:
      assert property (subsecond_irq |=> !subsecond_irq) else $error("sub-second pulse too long");
   AST_BASE_PAIR:
      assert property (subsecond_irq |-> subsecond_time_base)
         else $error("sub-second pulse without its tap");
endmodule : week_timer_counter_core_chk
bind week_timer_counter_core week_timer_counter_core_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .week_alarm_irq,
   .week_powerup_event, .subsecond_irq, .subsecond_time_base);

// ### test/test_week_timer_counter_core.sv
// self-checking bench for the week timer core
`timescale 1ns/1ps
module test_week_timer_counter_core
   import week_timer_pkg::*;
;
   localparam logic [31:0] MASK [5] = '{32'h1, 32'h0fff_ffff, 32'h0fff_ffff, 32'h7fff, 32'hf};
   logic aclk, aresetn, cnt_en;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, v, p1;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic week_alarm_irq, week_powerup_event, subsecond_irq, subsecond_time_base;
   logic [31:0] mdl [5] = '{32'h0, 32'h0, 32'h00ff_ffff, 32'h0, 32'h0};
   int n_errors = 0;
   int n_compared = 0;
   int n_pulse = 0;
   int n_base = 0;
   int p, pb, bb;
   week_timer_counter_core #(.CLK_FREQ_HZ(65536), .TICK_FREQ_HZ(32768)) dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .week_alarm_irq, .week_powerup_event, .subsecond_irq, .subsecond_time_base);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (cnt_en && subsecond_irq === 1'b1) n_pulse++;
      if (cnt_en && subsecond_time_base === 1'b1) n_base++;
   end
   task automatic end_sim();
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && s_axi_awready === 1'b1) begin
            s_axi_awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            s_axi_wvalid <= 1'b0;
            w = 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [1:0] er);
      logic ar;
      ar = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar && s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
            ar = 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd
   task automatic wm(input logic [4:0] a, input logic [31:0] d);
      wr(a, d, RESP_OKAY);
      mdl[a>>2] = d & MASK[a>>2];
   endtask : wm
   task automatic rdc(input logic [4:0] a);
      rd(a, RESP_OKAY);
      chk(rv, mdl[a>>2]);
   endtask : rdc
   initial begin
      #500_000;
      n_errors++;
      end_sim();
   end
   initial begin
      {aresetn, cnt_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 5'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
      {s_axi_awprot, s_axi_arprot} <= 6'h0;
      s_axi_wstrb <= 4'hf;
      v = $urandom(95882);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 5; i++) rdc(5'(i * 4));
      v = $urandom & 32'h0fff_fff0;
      wm(OFS_SECONDS, v | 32'hf000_0000);
      repeat (4) @(posedge aclk);
      rdc(OFS_SECONDS);
      wm(OFS_ALARM, v + 1);
      rdc(OFS_ALARM);
      chk(32'(week_alarm_irq), 32'h0);
      wm(OFS_ALARM, v);
      repeat (3) @(posedge aclk);
      chk(32'({week_alarm_irq, week_powerup_event}), 32'h3);
      wr(OFS_PRESCALER, 32'h1, RESP_SLVERR);
      rd(5'h1c, RESP_SLVERR);
      wm(OFS_ALARM, v + 2);
      wm(OFS_RATE, 1);
      wm(OFS_CONTROL, 1);
      repeat (6) @(posedge aclk);
      mdl[1] = v + 1;
      rdc(OFS_SECONDS);
      rd(OFS_PRESCALER, RESP_OKAY);
      p1 = rv;
      rd(OFS_PRESCALER, RESP_OKAY);
      chk(32'(rv > p1), 1);
      chk(32'(week_alarm_irq), 32'h0);
      pb = n_pulse;
      bb = n_base;
      cnt_en <= 1'b1;
      repeat (65536) @(posedge aclk);
      cnt_en <= 1'b0;
      mdl[1] = v + 2;
      rdc(OFS_SECONDS);
      chk(n_pulse - pb, 2);
      chk(n_base - bb, 32768);
      chk(32'(week_alarm_irq), 32'h1);
      wm(OFS_CONTROL, 0);
      repeat (4) @(posedge aclk);
      rdc(OFS_PRESCALER);
      rdc(OFS_SECONDS);
      wm(OFS_CONTROL, 1);
      for (int n = 0; n < 16; n++) begin
         wm(OFS_RATE, n);
         rdc(OFS_RATE);
         if (n == 0 || n > 4) begin
            p = (n == 0) ? 64 : (1 << (16 - n));
            repeat (p) @(posedge aclk);
            pb = n_pulse;
            bb = n_base;
            cnt_en <= 1'b1;
            repeat (2 * p) @(posedge aclk);
            cnt_en <= 1'b0;
            @(posedge aclk);
            chk(n_pulse - pb, (n == 0) ? 0 : 2);
            chk(n_base - bb, (n == 0) ? 0 : p);
         end
      end
      s_axi_wstrb <= 4'h2;
      wr(OFS_ALARM, 32'h1234_5678, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      mdl[2] = (mdl[2] & 32'hffff_00ff) | 32'h0000_5600;
      rdc(OFS_ALARM);
      mdl[1] = v + 3;
      rdc(OFS_SECONDS);
      end_sim();
   end
endmodule : test_week_timer_counter_core
